/* iosmc_pkg.sv */
/*
 * Package for the I/O state machine configuration block: register map, field
 * positions, reset values and the carrier structs shared by the design files.
 * Assumes a classic Wishbone slave with 32-bit data and byte addressing.
 */
package iosmc_pkg;

  localparam int unsigned IOSMC_ADDR_W = 8;

  // Register byte offsets.
  localparam logic [7:0] IOSMC_CLKDIV_OFS = 8'h00;
  localparam logic [7:0] IOSMC_EXECCTRL_OFS = 8'h04;
  localparam logic [7:0] IOSMC_SHIFTCTRL_OFS = 8'h08;
  localparam logic [7:0] IOSMC_PINCTRL_OFS = 8'h0c;
  localparam logic [7:0] IOSMC_CTRL_OFS = 8'h10;
  localparam logic [7:0] IOSMC_STATUS_OFS = 8'h14;
  localparam logic [7:0] IOSMC_STEP_OFS = 8'h18;

  // Divider field positions inside the divider register.
  localparam int unsigned IOSMC_DIV_FRAC_LSB = 8;
  localparam int unsigned IOSMC_DIV_INT_LSB = 16;

  // Reset values.
  localparam logic [15:0] IOSMC_DIV_INT_RST = 16'h0001;
  localparam logic [7:0] IOSMC_DIV_FRAC_RST = 8'h00;
  localparam logic [5:0] IOSMC_OUT_COUNT_RST = 6'h20;
  localparam logic [5:0] IOSMC_THRESH_RST = 6'h20;
  localparam logic [4:0] IOSMC_WRAP_TOP_RST = 5'h1f;
  localparam logic [4:0] IOSMC_WRAP_BOTTOM_RST = 5'h00;

  localparam logic [2:0] IOSMC_SIDE_MAX = 3'h5;
  localparam logic [2:0] IOSMC_IMM_MAX = 3'h5;
  localparam logic [5:0] IOSMC_PIN_MAX = 6'h20;

  typedef enum logic [1:0] {
    IOSMC_STAT_TX_BELOW = 2'h0,
    IOSMC_STAT_RX_BELOW = 2'h1
  } iosmc_stat_sel_t;

  // Execution control: EXECCTRL register layout, MSB first.
  typedef struct packed {
    logic [5:0] status_n;          // [31:26]
    logic side_en;                 // [25] optional side-drive flag
    logic side_pindir;             // [24]
    logic [4:0] branch_pin;        // [23:19]
    logic [4:0] aux_en_idx;        // [18:14]
    logic aux_en;                  // [13]
    logic sticky;                  // [12]
    logic [4:0] loop_top;          // [11:7]
    logic [4:0] loop_return_addr;  // [6:2]
    logic [1:0] status_sel;        // [1:0]
  } iosmc_exec_t;

  // Shift control: SHIFTCTRL register layout.
  typedef struct packed {
    logic [17:0] rsvd;             // [31:14]
    logic [5:0] out_thresh;        // [13:8]
    logic [1:0] rsvd2;             // [7:6]
    logic [1:0] rsvd3;             // [5:4]
    logic out_right;               // [3]
    logic in_right;                // [2]
    logic auto_refill;             // [1]
    logic auto_deposit;            // [0]
  } iosmc_shift_hdr_t;

  // Pin control: PINCTRL register layout.
  typedef struct packed {
    logic [2:0] side_count;        // [31:29]
    logic [2:0] imm_count;         // [28:26]
    logic [5:0] out_count;         // [25:20]
    logic [4:0] side_base;         // [19:15]
    logic [4:0] imm_base;          // [14:10]
    logic [4:0] in_base;           // [9:5]
    logic [4:0] out_base;          // [4:0]
  } iosmc_pin_t;

  // Pin write request from the datapath to the pin mapper.
  typedef struct packed {
    logic out_wr;
    logic [31:0] out_data;
    logic imm_wr;
    logic [4:0] imm_data;
    logic imm_dir;
    logic side_wr;
    logic [4:0] side_data;
  } iosmc_pinreq_t;

endpackage

/* iosmc_clkdiv.sv */
/*
 * Fractional clock-enable generator for the I/O state machine.
 * Assumes the divisor inputs come from registers in the same clock domain.
 */
`timescale 1ns/1ps
module iosmc_clkdiv #(
  parameter int unsigned INT_W = 16,
  parameter int unsigned FRAC_W = 8
) (
  input wire logic clock_i,              // System clock.
  input wire logic srst_i,               // Synchronous reset, active high.
  input wire logic run_i,                // Machine enabled.
  input wire logic [INT_W-1:0] div_int_i, // Integer divisor part.
  input wire logic [FRAC_W-1:0] div_frac_i, // Fraction in 1/256ths.
  output logic adv_o                     // One-cycle advance strobe.
);
  import iosmc_pkg::*;

  typedef struct packed {
    logic [INT_W+FRAC_W-1:0] acc;
    logic adv;
  } iosmc_div_st_t;

  iosmc_div_st_t st_ff;
  iosmc_div_st_t nxt_st;
  logic [INT_W+FRAC_W-1:0] step;
  logic [INT_W+FRAC_W-1:0] div;
  logic [INT_W+FRAC_W-1:0] one;

  // A gated enable keeps everything on one clock; no derived clock tree.
  always_comb begin
    one = {{(INT_W-1){1'b0}}, 1'b1, {FRAC_W{1'b0}}};
    div = {div_int_i, div_frac_i};
    // An integer part of zero counts as a divisor of 32768.
    if (div_int_i == '0) begin
      div = {1'b1, {(INT_W+FRAC_W-1){1'b0}}};
    end
    step = st_ff.acc + one;
    nxt_st = st_ff;
    nxt_st.adv = 1'b0;
    if (!run_i) begin
      nxt_st.acc = '0;
    end else if (step >= div) begin
      // Fraction remainder carries over, so a non-integer divisor spaces
      // enables unevenly: 2.5 gives gaps of 2 and 3.
      nxt_st.acc = step - div;
      nxt_st.adv = 1'b1; // One cycle in n for an integer n; n=1 every cycle.
    end else begin
      nxt_st.acc = step;
    end
  end

  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign adv_o = st_ff.adv;

endmodule

/* iosmc_pinmap.sv */
/*
 * Pin mapper: places output, immediate and side-drive writes onto the 32
 * pin value and direction lines, with sticky re-assertion.
 * Assumes requests arrive as one-cycle strobes qualified by the advance.
 */
`timescale 1ns/1ps
module iosmc_pinmap #(
  parameter int unsigned PINS = 32
) (
  input wire logic clock_i,                 // System clock.
  input wire logic srst_i,                  // Synchronous reset, active high.
  input wire logic adv_i,                   // Advance strobe.
  input iosmc_pkg::iosmc_pin_t pin_i,       // Pin group configuration.
  input wire logic sticky_i,                // Sticky output enable.
  input wire logic side_pindir_i,           // Side-drive drives directions.
  input iosmc_pkg::iosmc_pinreq_t req_i,    // Pin write request.
  output logic [PINS-1:0] pin_val_o,        // Pin output values.
  output logic [PINS-1:0] pin_dir_o         // Pin directions, 1 = out.
);
  import iosmc_pkg::*;

  typedef struct packed {
    logic [PINS-1:0] val;
    logic [PINS-1:0] dir;
    logic [PINS-1:0] last_val;
    logic [PINS-1:0] last_msk;
  } iosmc_map_st_t;

  iosmc_map_st_t st_ff;
  iosmc_map_st_t nxt_st;
  logic [PINS-1:0] out_msk;
  logic [PINS-1:0] out_val;
  logic [PINS-1:0] imm_msk;
  logic [PINS-1:0] imm_val;
  logic [PINS-1:0] side_msk;
  logic [PINS-1:0] side_val;

  // Each group rotates from its own base, so groups may share any pin.
  for (genvar g = 0; g < PINS; g++) begin : g_pin
    localparam logic [4:0] PIDX = 5'(g);
    logic [4:0] ro;
    logic [4:0] ri;
    logic [4:0] rs;
    assign ro = PIDX - pin_i.out_base;
    assign ri = PIDX - pin_i.imm_base;
    assign rs = PIDX - pin_i.side_base;
    assign out_msk[g] = {1'b0, ro} < pin_i.out_count;
    assign out_val[g] = req_i.out_data[ro];
    assign imm_msk[g] = {2'b00, ri} < {3'b000, pin_i.imm_count};
    assign imm_val[g] = (ri < 5'h05) ? req_i.imm_data[ri[2:0]] : 1'b0;
    assign side_msk[g] = {2'b00, rs} < {3'b000, pin_i.side_count};
    assign side_val[g] = (rs < 5'h05) ? req_i.side_data[rs[2:0]] : 1'b0;
  end

  always_comb begin
    nxt_st = st_ff;
    if (adv_i) begin
      if (req_i.out_wr) begin
        nxt_st.val = (st_ff.val & ~out_msk) | (out_val & out_msk);
        nxt_st.last_val = (st_ff.last_val & ~out_msk) | (out_val & out_msk);
        nxt_st.last_msk = out_msk;
      end
      if (req_i.imm_wr && !req_i.imm_dir) begin
        nxt_st.val = (nxt_st.val & ~imm_msk) | (imm_val & imm_msk);
        nxt_st.last_val = (nxt_st.last_val & ~imm_msk) | (imm_val & imm_msk);
        nxt_st.last_msk = imm_msk;
      end else if (req_i.imm_wr) begin
        nxt_st.dir = (st_ff.dir & ~imm_msk) | (imm_val & imm_msk);
      end
      // Re-assert the last output or immediate values when idle.
      if (sticky_i && !req_i.out_wr && !req_i.imm_wr) begin
        nxt_st.val = (st_ff.val & ~st_ff.last_msk) | (st_ff.last_val & st_ff.last_msk);
      end
      // Side-drive lands last so it wins over a same-cycle data write.
      if (req_i.side_wr) begin
        if (side_pindir_i) begin
          nxt_st.dir = (nxt_st.dir & ~side_msk) | (side_val & side_msk);
        end else begin
          nxt_st.val = (nxt_st.val & ~side_msk) | (side_val & side_msk);
        end
      end
    end
  end

  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign pin_val_o = st_ff.val;
  assign pin_dir_o = st_ff.dir;

endmodule

/* iosmc_top.sv */
/*
 * Configuration and execution control for one programmable I/O state
 * machine: Wishbone registers, divider, shift registers and pin mapping.
 * Assumes a classic Wishbone master and GPIO inputs synchronous to clock_i.
 */
// Decided for this implementation: the Wishbone register port and the register addresses.
`timescale 1ns/1ps
module iosmc_top (
  input wire logic clock_i,                 // System clock, 125 MHz.
  input wire logic srst_i,                  // Synchronous reset, active high.
  input wire logic wb_cyc_i,                // Wishbone cycle.
  input wire logic wb_stb_i,                // Wishbone strobe.
  input wire logic wb_we_i,                 // Wishbone write enable.
  input wire logic [iosmc_pkg::IOSMC_ADDR_W-1:0] wb_adr_i, // Byte address.
  input wire logic [3:0] wb_sel_i,          // Byte enables.
  input wire logic [31:0] wb_dat_i,         // Write data.
  output logic [31:0] wb_dat_o,             // Read data.
  output logic wb_ack_o,                    // Acknowledge.
  input wire logic [31:0] gpio_i,           // GPIO input levels.
  input wire logic tx_data_valid_i,         // Refill word available.
  input wire logic [31:0] tx_data_i,        // Refill word.
  input wire logic [2:0] tx_level_i,        // Transmit queue level.
  input wire logic [2:0] rx_level_i,        // Receive queue level.
  output logic tx_pop_o,                    // Refill taken, one cycle.
  output logic rx_push_o,                   // Deposit strobe, one cycle.
  output logic [31:0] rx_data_o,            // Deposited word.
  output logic [31:0] pin_val_o,            // Pin output values.
  output logic [31:0] pin_dir_o,            // Pin directions, 1 = out.
  output logic adv_o,                       // Advance strobe, delayed by one cycle.
  output logic branch_pin_o,                // Sampled branch pin level.
  output logic status_o                     // Status-move comparison result.
);
  import iosmc_pkg::*;

  typedef struct packed {
    logic [15:0] div_int;
    logic [7:0] div_frac;
    iosmc_exec_t exe;
    iosmc_shift_hdr_t shf;
    logic [5:0] in_thresh;
    iosmc_pin_t pin;
    logic run;
    logic [15:0] step;          // Pending step word.
    logic step_go;
    // Latched configuration for the step in progress.
    iosmc_pin_t act_pin;
    logic [2:0] act_side_cnt;
    // Datapath.
    logic [4:0] pc;
    logic [4:0] dly;
    logic [31:0] isr;
    logic [31:0] osr;
    logic [5:0] isr_cnt;
    logic [5:0] osr_cnt;
    logic [31:0] x;
    // Bus and output registers.
    logic ack;
    logic [31:0] rdat;
    logic tx_pop;
    logic rx_push;
    logic [31:0] rx_data;
    logic branch_pin;
    logic status;
  } iosmc_st_t;

  iosmc_st_t st_ff;
  iosmc_st_t nxt_st;
  logic adv;
  logic adv_ff;
  iosmc_pinreq_t req;
  logic wb_hit;
  logic [31:0] wmask;
  logic [31:0] rd_mux;
  logic [2:0] side_bits;
  logic [4:0] side_raw;
  logic [4:0] dly_raw;
  logic side_apply;
  logic [5:0] nbits;
  logic [31:0] in_word;
  logic [31:0] out_word;
  logic [4:0] delay_msk;

  iosmc_clkdiv #(.INT_W(16), .FRAC_W(8)) u_div (
    .clock_i(clock_i),
    .srst_i(srst_i),
    .run_i(st_ff.run),
    .div_int_i(st_ff.div_int),
    .div_frac_i(st_ff.div_frac),
    .adv_o(adv)
  );

  iosmc_pinmap #(.PINS(32)) u_pins (
    .clock_i(clock_i),
    .srst_i(srst_i),
    .adv_i(adv),
    .pin_i(st_ff.act_pin),
    .sticky_i(st_ff.exe.sticky),
    .side_pindir_i(st_ff.exe.side_pindir),
    .req_i(req),
    .pin_val_o(pin_val_o),
    .pin_dir_o(pin_dir_o)
  );

  // Step word: [15:13] op, [12:8] side/delay field, [7:0] operand.
  // op 0 nop, 1 shift-in from pins, 2 shift-out to pins, 3 immediate value,
  // 4 immediate direction, 5 branch on pin to operand address.
  always_comb begin
    side_bits = (st_ff.act_side_cnt > IOSMC_SIDE_MAX) ? IOSMC_SIDE_MAX : st_ff.act_side_cnt;
    side_raw = st_ff.step[12:8] >> (3'h5 - side_bits);
    // Side-drive bits are stolen from the top of the delay field.
    delay_msk = 5'h1f >> side_bits;
    dly_raw = st_ff.step[12:8] & delay_msk;
    side_apply = (side_bits != 3'h0);
    if (st_ff.exe.side_en && side_bits != 3'h0) begin
      // Top side bit is the per-step apply flag.
      side_apply = side_raw[side_bits-3'h1];
      side_raw = side_raw & ~(5'h01 << (side_bits - 3'h1));
    end
    nbits = (st_ff.step[5:0] == 6'h00 || st_ff.step[5:0] > IOSMC_PIN_MAX) ?
            IOSMC_PIN_MAX : st_ff.step[5:0];
    // Input pins read from the in base upward.
    in_word = (gpio_i >> st_ff.act_pin.in_base) | (gpio_i << (6'h20 - {1'b0, st_ff.act_pin.in_base}));
    out_word = st_ff.shf.out_right ? st_ff.osr : (st_ff.osr >> (6'h20 - nbits));
    req = '0;
    req.side_wr = side_apply && st_ff.step_go && st_ff.dly == 5'h00;
    req.side_data = side_raw;
    if (st_ff.step_go && st_ff.dly == 5'h00) begin
      unique case (st_ff.step[15:13])
        3'h2: begin
          // Auxiliary enable bit of the shifted data gates the pin write.
          req.out_wr = !st_ff.exe.aux_en || st_ff.osr[st_ff.exe.aux_en_idx];
          req.out_data = out_word;
        end
        3'h3: begin
          req.imm_wr = 1'b1;
          req.imm_data = st_ff.step[4:0];
        end
        3'h4: begin
          req.imm_wr = 1'b1;
          req.imm_dir = 1'b1;
          req.imm_data = st_ff.step[4:0];
        end
        default: begin
          req.out_wr = 1'b0;
        end
      endcase
    end
  end

  // Wishbone decode and write masking.
  always_comb begin
    wb_hit = wb_cyc_i && wb_stb_i && !st_ff.ack;
    wmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
    unique case (wb_adr_i)
      IOSMC_CLKDIV_OFS: rd_mux = {st_ff.div_int, st_ff.div_frac, 8'h00};
      IOSMC_EXECCTRL_OFS: rd_mux = st_ff.exe;
      IOSMC_SHIFTCTRL_OFS: rd_mux = {10'h000, st_ff.in_thresh, 2'h0, st_ff.shf.out_thresh,
                                     4'h0, st_ff.shf[3:0]};
      IOSMC_PINCTRL_OFS: rd_mux = st_ff.pin;
      IOSMC_CTRL_OFS: rd_mux = {31'h0, st_ff.run};
      IOSMC_STATUS_OFS: rd_mux = {st_ff.isr_cnt, st_ff.osr_cnt, st_ff.pc, st_ff.dly,
                                  8'h00, st_ff.status, st_ff.branch_pin};
      IOSMC_STEP_OFS: rd_mux = {15'h0, st_ff.step_go, st_ff.step};
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  always_comb begin
    nxt_st = st_ff;
    nxt_st.ack = wb_hit;
    nxt_st.rdat = wb_hit ? rd_mux : 32'h0000_0000;
    nxt_st.tx_pop = 1'b0;
    nxt_st.rx_push = 1'b0;
    if (wb_hit && wb_we_i) begin
      unique case (wb_adr_i)
        IOSMC_CLKDIV_OFS: begin
          nxt_st.div_int = (st_ff.div_int & ~wmask[31:16]) | (wb_dat_i[31:16] & wmask[31:16]);
          nxt_st.div_frac = (st_ff.div_frac & ~wmask[15:8]) | (wb_dat_i[15:8] & wmask[15:8]);
        end
        IOSMC_EXECCTRL_OFS: nxt_st.exe = (st_ff.exe & ~wmask) | (wb_dat_i & wmask);
        IOSMC_SHIFTCTRL_OFS: begin
          if (wb_sel_i[0]) nxt_st.shf[3:0] = wb_dat_i[3:0];
          if (wb_sel_i[1]) nxt_st.shf.out_thresh = wb_dat_i[13:8];
          if (wb_sel_i[2]) nxt_st.in_thresh = wb_dat_i[21:16];
        end
        IOSMC_PINCTRL_OFS: nxt_st.pin = (st_ff.pin & ~wmask) | (wb_dat_i & wmask);
        IOSMC_CTRL_OFS: if (wb_sel_i[0]) nxt_st.run = wb_dat_i[0];
        IOSMC_STEP_OFS: begin
          // A new step is refused while one is still running. Steps move only on
          // an advance, so a stopped machine never executes one.
          if (!st_ff.step_go && wb_sel_i[1:0] == 2'h3) begin
            nxt_st.step = wb_dat_i[15:0];
            nxt_st.step_go = 1'b1;
            // Pin and side sizing are frozen for the whole step.
            nxt_st.act_pin = st_ff.pin;
            nxt_st.act_side_cnt = st_ff.pin.side_count;
          end
        end
        default: nxt_st.run = st_ff.run;
      endcase
    end
    // Clamp illegal pin counts to their documented maximum.
    if (nxt_st.pin.out_count > IOSMC_PIN_MAX) nxt_st.pin.out_count = IOSMC_PIN_MAX;
    if (nxt_st.pin.imm_count > IOSMC_IMM_MAX) nxt_st.pin.imm_count = IOSMC_IMM_MAX;
    if (nxt_st.pin.side_count > IOSMC_SIDE_MAX) nxt_st.pin.side_count = IOSMC_SIDE_MAX;
    // Everything below moves only on an advance; other cycles hold.
    if (adv) begin
      // Branch pin is an absolute GPIO number.
      nxt_st.branch_pin = gpio_i[st_ff.exe.branch_pin];
      nxt_st.status = (st_ff.exe.status_sel == IOSMC_STAT_RX_BELOW) ?
                      ({3'h0, rx_level_i} < st_ff.exe.status_n) :
                      ({3'h0, tx_level_i} < st_ff.exe.status_n);
      if (st_ff.step_go && st_ff.dly != 5'h00) begin
        nxt_st.dly = st_ff.dly - 5'h01;
        if (st_ff.dly == 5'h01) nxt_st.step_go = 1'b0;
      end else if (st_ff.step_go) begin
        nxt_st.dly = dly_raw;
        nxt_st.step_go = (dly_raw != 5'h00);
        nxt_st.pc = (st_ff.pc == st_ff.exe.loop_top) ? st_ff.exe.loop_return_addr :
                    st_ff.pc + 5'h01;
        unique case (st_ff.step[15:13])
          3'h1: begin
            nxt_st.isr = st_ff.shf.in_right ?
                         ((st_ff.isr >> nbits) | (in_word << (6'h20 - nbits))) :
                         ((st_ff.isr << nbits) | (in_word & ~(32'hffff_ffff << nbits)));
            nxt_st.isr_cnt = ({1'b0, st_ff.isr_cnt} + {1'b0, nbits} > {1'b0, IOSMC_PIN_MAX}) ?
                             IOSMC_PIN_MAX :
                             6'(st_ff.isr_cnt + nbits);
            // Deposit once the threshold is reached.
            if (st_ff.shf.auto_deposit && nxt_st.isr_cnt >= st_ff.in_thresh) begin
              nxt_st.rx_push = 1'b1;
              nxt_st.rx_data = nxt_st.isr;
              nxt_st.isr = 32'h0000_0000;
              nxt_st.isr_cnt = 6'h00;
            end
          end
          3'h2: begin
            nxt_st.osr = st_ff.shf.out_right ? (st_ff.osr >> nbits) : (st_ff.osr << nbits);
            nxt_st.osr_cnt = ({1'b0, st_ff.osr_cnt} + {1'b0, nbits} > {1'b0, IOSMC_PIN_MAX}) ?
                             IOSMC_PIN_MAX :
                             6'(st_ff.osr_cnt + nbits);
            // Refill once the threshold has gone out.
            if (st_ff.shf.auto_refill && nxt_st.osr_cnt >= st_ff.shf.out_thresh &&
                tx_data_valid_i) begin
              nxt_st.tx_pop = 1'b1;
              nxt_st.osr = tx_data_i;
              nxt_st.osr_cnt = 6'h00;
            end
          end
          3'h5: if (gpio_i[st_ff.exe.branch_pin]) nxt_st.pc = st_ff.step[4:0];
          default: nxt_st.x = st_ff.x;
        endcase
      end
    end
  end

  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      st_ff <= '0;
      st_ff.div_int <= IOSMC_DIV_INT_RST;
      st_ff.div_frac <= IOSMC_DIV_FRAC_RST;
      // Defaults: right shifts, autos off, both thresholds 32.
      st_ff.exe.loop_top <= IOSMC_WRAP_TOP_RST;
      st_ff.exe.loop_return_addr <= IOSMC_WRAP_BOTTOM_RST;
      st_ff.exe.status_sel <= IOSMC_STAT_TX_BELOW;
      st_ff.shf.in_right <= 1'b1;
      st_ff.shf.out_right <= 1'b1;
      st_ff.shf.out_thresh <= IOSMC_THRESH_RST;
      st_ff.in_thresh <= IOSMC_THRESH_RST;
      // Defaults: 32 output pins at 0, no immediate pins, side off.
      st_ff.pin.out_count <= IOSMC_OUT_COUNT_RST;
      st_ff.act_pin.out_count <= IOSMC_OUT_COUNT_RST;
      adv_ff <= 1'b0;
    end else begin
      st_ff <= nxt_st;
      adv_ff <= adv;
    end
  end

  assign wb_ack_o = st_ff.ack;
  assign wb_dat_o = st_ff.rdat;
  assign tx_pop_o = st_ff.tx_pop;
  assign rx_push_o = st_ff.rx_push;
  assign rx_data_o = st_ff.rx_data;
  assign adv_o = adv_ff;
  assign branch_pin_o = st_ff.branch_pin;
  assign status_o = st_ff.status;

endmodule

/* iosmc_gpio_model.sv */
/* Pad model for the pins of iosmc_top.
   Assumes 32 pads; the bench sets the level of undriven pads. */
`timescale 1ns/1ps
module iosmc_gpio_model (
  input wire logic [31:0] pin_val_i, // Values.
  input wire logic [31:0] pin_dir_i, // 1 = driven.
  input wire logic [31:0] ext_i, // Outside level.
  output logic [31:0] gpio_o // Pad levels.
);
  // One pad per bit, so overlapping groups just meet on the same pad.
  assign gpio_o = (pin_dir_i & pin_val_i) | (~pin_dir_i & ext_i);
endmodule

/* iosmc_monitor.sv */
/* Port checker bound to iosmc_top.
   Assumes one clock with a synchronous reset. */
`timescale 1ns/1ps
module iosmc_monitor (
  input wire logic clock_i, // Clock.
  input wire logic srst_i, // Reset.
  input wire logic wb_cyc_i, // Cycle.
  input wire logic wb_stb_i, // Strobe.
  input wire logic [31:0] wb_dat_o, // Data.
  input wire logic wb_ack_o, // Ack.
  input wire logic tx_data_valid_i, // Valid.
  input wire logic tx_pop_o, // Refill.
  input wire logic rx_push_o, // Deposit.
  input wire logic [31:0] pin_val_o, // Pins.
  input wire logic adv_o, // Advance.
  input wire logic status_o // Status.
);
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (srst_i);
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack too long");
  ack_lat_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack late");
  dat_idle_a: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
    else $error("stray data");
  rst_quiet_a: assert property (disable iff (1'b0)
    srst_i |=> !wb_ack_o && !adv_o && pin_val_o == 32'h0) else $error("reset");
  pop_cause_a: assert property (tx_pop_o |-> adv_o && $past(tx_data_valid_i))
    else $error("bad refill");
  push_adv_a: assert property (rx_push_o |-> adv_o)
    else $error("bad deposit");
  pins_hold_a: assert property ($changed(pin_val_o) |-> adv_o)
    else $error("pins moved");
  status_hold_a: assert property ($changed(status_o) |-> adv_o)
    else $error("status moved");
  cover property (rx_push_o);
  cover property (tx_pop_o);
  cover property (adv_o ##1 !adv_o ##1 !adv_o ##1 adv_o);
endmodule
bind iosmc_top iosmc_monitor i_iosmc_monitor (.clock_i(clock_i), .srst_i(srst_i),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .tx_data_valid_i(tx_data_valid_i), .tx_pop_o(tx_pop_o), .rx_push_o(rx_push_o),
  .pin_val_o(pin_val_o), .adv_o(adv_o), .status_o(status_o));

/* iosmc_top_bench.sv */
/* Self-checking bench for iosmc_top.
   Assumes the checker binds itself and the pad model stands on the pins. */
`timescale 1ns/1ps
module iosmc_top_bench;
  import iosmc_pkg::*;
  logic clk = 0, rst = 1, cyc = 0, stb = 0, we = 0, txv = 0;
  logic [IOSMC_ADDR_W-1:0] adr = 8'h00;
  logic [31:0] dat = 32'h0, ext = 32'h5a3c96e1, q, rdat, rxd, pv, pd, gpio;
  logic ack, pop, push, adv, bp, st;
  logic [1:0] seen = 2'b00;
  int fails = 0, samples_checked = 0, cycles = 0;
  always #4 clk = ~clk;
  iosmc_top i_iosmc_top (.clock_i(clk), .srst_i(rst), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(dat), .wb_dat_o(rdat),
    .wb_ack_o(ack), .gpio_i(gpio), .tx_data_valid_i(txv), .tx_data_i(32'hc3a50f96),
    .tx_level_i(3'h0), .rx_level_i(3'h0), .tx_pop_o(pop), .rx_push_o(push),
    .rx_data_o(rxd), .pin_val_o(pv), .pin_dir_o(pd), .adv_o(adv), .branch_pin_o(bp),
    .status_o(st));
  iosmc_gpio_model i_iosmc_gpio_model (.pin_val_i(pv), .pin_dir_i(pd), .ext_i(ext),
    .gpio_o(gpio));
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    samples_checked++;
    if (g !== e) begin
      fails++;
      $display("[ERR] %0t %h %h", $time, g, e);
    end
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    {cyc, stb, we, adr, dat} <= {2'b11, w, a, d};
    do @(posedge clk); while (ack !== 1'b1);
    q = rdat;
    {cyc, stb} <= 2'b00;
    @(posedge clk);
  endtask
  task automatic step(input logic [31:0] w);
    wb(1'b1, IOSMC_STEP_OFS, w);
    repeat (6) @(posedge clk);
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // Pulses are latched here so a late look inside a step cannot miss them.
  always @(posedge clk) begin
    cycles <= cycles + 1;
    seen <= seen | {pop === 1'b1, push === 1'b1};
    if (cycles == 20000) begin
      fails++;
      complete_run();
    end
  end
  task automatic t_regs();
    logic [31:0] e [4] = '{32'h00010000, 32'h00000f80, 32'h0020200c, 32'h02000000};
    for (int i = 0; i < 4; i++) begin
      wb(1'b0, 8'(i * 4), 32'h0);
      chk(q, e[i]);
    end
    wb(1'b1, 8'h1c, 32'hffffffff);
    wb(1'b0, 8'h1c, 32'h0);
    chk(q, 32'h0);
  endtask
  task automatic t_div(input logic [31:0] div, input logic [31:0] n);
    logic [31:0] c;
    c = 0;
    wb(1'b1, IOSMC_CLKDIV_OFS, div);
    repeat (10) @(posedge clk);
    repeat (60) begin
      @(posedge clk);
      c += adv;
    end
    chk(c, n);
  endtask
  task automatic t_shift();
    wb(1'b1, IOSMC_SHIFTCTRL_OFS, 32'h0020200f);
    txv <= 1'b1;
    step(32'h00002000);
    chk(rxd, 32'h5a3c96e1);
    step(32'h00004000);
    step(32'h00004000);
    chk(pv, 32'hc3a50f96);
    chk({30'h0, seen}, 32'h3);
  endtask
  task automatic t_pins();
    wb(1'b1, IOSMC_PINCTRL_OFS, 32'h0e001000);
    wb(1'b1, IOSMC_EXECCTRL_OFS, 32'h04380f80);
    step(32'h00006005);
    chk(pv, 32'hc3a50fd6);
    step(32'h00008007);
    chk(pd, 32'h00000070);
    step(32'h0000a000);
    chk({30'h0, st, bp}, 32'h3);
  endtask
  initial begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_regs();
    wb(1'b1, IOSMC_CTRL_OFS, 32'h1);
    t_div(32'h00030000, 32'd20);
    t_div(32'h00028000, 32'd24);
    t_div(32'h00010000, 32'd60);
    t_shift();
    t_pins();
    complete_run();
  end
endmodule
